// ===== src/dpd_pkg.sv
package dpd_pkg;
  // ----------------------------------------
  // code and timing constants
  // ----------------------------------------
  localparam int          CODE_W        = 6;
  localparam logic [5:0]  CODE_HALF     = 6'h20;
  localparam logic [5:0]  CODE_MAX      = 6'h3f;
  localparam logic [5:0]  CODE_MIN      = 6'h00;
  localparam logic [5:0]  CODE_STEP     = 6'h01;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          PWM_HZ        = 5_000;
  // one pwm period is 64 slots, so the slot tick is pwm rate times 64
  localparam int          SLOT_CYC      = CLK_HZ / (PWM_HZ * 64);
  localparam int          DEB_US        = 12_800;
  localparam int          DEB_CYC       = (CLK_HZ / 1_000_000) * DEB_US;
  localparam int          DELAY_MS      = 410;
  localparam int          DELAY_CYC     = (CLK_HZ / 1_000) * DELAY_MS;
  // 19.5 Hz held as tenths of hertz
  localparam int          REP_DHZ       = 195;
  localparam int          REP_CYC       = (CLK_HZ * 10) / REP_DHZ;
  localparam int          TMR_W         = 25;

  // ----------------------------------------
  // mode and button states
  // ----------------------------------------
  typedef enum logic {DPD_PULSE, DPD_BUTTON} dpd_mode_t;
  typedef enum logic [1:0] {DPD_IDLE, DPD_FIRST, DPD_REPEAT} dpd_btn_t;
endpackage

// ===== src/dpd_top.sv
// Contract
// - each channel holds independent 6-bit code
// - each tap input changes only its code
// - mode sampled at start-up, then fixed
// - both floating gives pushbutton, else pulse
// - pulse mode only increments
// - pulse adds one, wraps to zero
// - button high up, low down, saturating
// - codes start at half scale
// - code 63 near full, zero stays low
// - output period nominally 5 kHz
// - pushbutton input debounced 12.8 ms
// - auto-repeat starts 410 ms after step
// - repeat steps at 19.5 Hz while held
// - sleep low tri-states both outputs
// - codes kept through sleep
module dpd_top
  import dpd_pkg::*;
#(
  parameter int DEB_CYCLES   = DEB_CYC,
  parameter int DELAY_CYCLES = DELAY_CYC,
  parameter int REP_CYCLES   = REP_CYC,
  parameter int SLOT_CYCLES  = SLOT_CYC
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // mode strap: three-level sense, floating flagged per pin
  input  wire logic i_chan1_float,
  input  wire logic i_chan2_float,
  // tap inputs and sleep request
  input  wire logic i_chan1_tap_input,
  input  wire logic i_chan2_tap_input,
  input  wire logic i_sleep_request_n,
  // duty outputs with enables
  output logic      o_chan1_duty_output,
  output logic      o_chan1_duty_oe,
  output logic      o_chan2_duty_output,
  output logic      o_chan2_duty_oe
);
  import dpd_pkg::*;

  // ----------------------------------------
  // mode strap capture
  // ----------------------------------------
  dpd_mode_t mode;
  logic      strap_done;

  // async reset loads a constant; the pins are caught on the first clock after release
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode       <= DPD_PULSE;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      mode       <= (i_chan1_float && i_chan2_float) ? DPD_BUTTON : DPD_PULSE;
    end
  end

  // ----------------------------------------
  // pwm period counter
  // ----------------------------------------
  logic [TMR_W-1:0]  slot_tmr;
  logic [CODE_W-1:0] period_cnt;
  logic              slot_tick;

  assign slot_tick = (slot_tmr == TMR_W'(SLOT_CYCLES - 1));

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_tmr   <= '0;
      period_cnt <= '0;
    end else begin
      slot_tmr <= slot_tick ? '0 : slot_tmr + TMR_W'(1);
      if (slot_tick) begin
        period_cnt <= period_cnt + CODE_W'(1);
      end
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  logic [1:0] taps;
  logic [1:0] duty;
  assign taps = {i_chan2_tap_input, i_chan1_tap_input};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] shadow;
    logic              tap_q;
    logic              stable;
    logic              stable_q;
    logic [TMR_W-1:0]  deb_tmr;
    logic [TMR_W-1:0]  rep_tmr;
    dpd_btn_t          btn;
    logic              press;
    logic              step;
    logic              up;
    logic              duty_q;

    // ---- pulse edge and debounce ----
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        tap_q    <= 1'b0;
        stable   <= 1'b0;
        stable_q <= 1'b0;
        deb_tmr  <= '0;
      end else begin
        tap_q    <= taps[ch];
        stable_q <= stable;
        // a bouncing level restarts the filter, so only a settled level is seen
        if (taps[ch] != tap_q) begin
          deb_tmr <= '0;
        end else if (deb_tmr == TMR_W'(DEB_CYCLES - 1)) begin
          stable  <= tap_q;
        end else begin
          deb_tmr <= deb_tmr + TMR_W'(1);
        end
      end
    end

    // a float-sense front end reports press high or low; here the idle level
    // after debounce is taken as the level seen at release of a press
    assign press = (stable != stable_q);
    assign up    = stable;

    // ---- button auto-repeat ----
    // every settled transition is a fresh press of its own polarity, so a
    // reversal in mid-repeat steps at once and restarts the hold delay
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        btn     <= DPD_IDLE;
        rep_tmr <= '0;
      end else if (mode != DPD_BUTTON) begin
        btn     <= DPD_IDLE;
        rep_tmr <= '0;
      end else if (press) begin
        btn     <= DPD_FIRST;
        rep_tmr <= '0;
      end else begin
        case (btn)
          DPD_IDLE: begin
            rep_tmr <= '0;
          end
          DPD_FIRST: begin
            if (rep_tmr == TMR_W'(DELAY_CYCLES - 1)) begin
              btn     <= DPD_REPEAT;
              rep_tmr <= '0;
            end else begin
              rep_tmr <= rep_tmr + TMR_W'(1);
            end
          end
          DPD_REPEAT: begin
            if (rep_tmr == TMR_W'(REP_CYCLES - 1)) begin
              rep_tmr <= '0;
            end else begin
              rep_tmr <= rep_tmr + TMR_W'(1);
            end
          end
          default: btn <= DPD_IDLE;
        endcase
      end
    end

    // a press and a timer expiry in one cycle still give a single step
    assign step = (mode == DPD_PULSE)
                ? (taps[ch] && !tap_q)
                : (press
                   || (btn == DPD_FIRST && rep_tmr == TMR_W'(DELAY_CYCLES - 1))
                   || (btn == DPD_REPEAT && rep_tmr == TMR_W'(REP_CYCLES - 1)));

    // ---- code register; sleep does not touch it ----
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        code <= CODE_HALF;
      end else if (step && strap_done) begin
        if (mode == DPD_PULSE) begin
          code <= code + CODE_STEP;
        end else if (up && code != CODE_MAX) begin
          code <= code + CODE_STEP;
        end else if (!up && code != CODE_MIN) begin
          code <= code - CODE_STEP;
        end
      end
    end

    // ---- period-aligned shadow and compare ----
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        shadow <= CODE_HALF;
        duty_q <= 1'b0;
      end else begin
        if (slot_tick && period_cnt == CODE_MAX) begin
          shadow <= code;
        end
        duty_q <= (period_cnt < shadow);
      end
    end

    // one process per bit keeps each channel's level single-driven
    assign duty[ch] = duty_q;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chan1_duty_output <= 1'b0;
      o_chan2_duty_output <= 1'b0;
      o_chan1_duty_oe     <= 1'b0;
      o_chan2_duty_oe     <= 1'b0;
    end else begin
      o_chan1_duty_output <= duty[0];
      o_chan2_duty_output <= duty[1];
      o_chan1_duty_oe     <= i_sleep_request_n;
      o_chan2_duty_oe     <= i_sleep_request_n;
    end
  end
endmodule // dpd_top

// ===== verif/dpd_monitor.sv
module dpd_monitor
  import dpd_pkg::*;
#(
  parameter int SLOT_CYCLES = 156
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sleep_request_n,
  input wire logic o_chan1_duty_output,
  input wire logic o_chan1_duty_oe,
  input wire logic o_chan2_duty_output,
  input wire logic o_chan2_duty_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // longest legal high run: full code still leaves one slot low
  localparam logic [15:0] HIGH_MAX = 16'(int'(CODE_MAX) * SLOT_CYCLES);
  logic [15:0] run_one;
  logic [15:0] run_two;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // a counter, since a full-length period is far beyond any delay range
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_one <= '0;
      run_two <= '0;
    end else begin
      run_one <= o_chan1_duty_output ? run_one + 16'h0001 : '0;
      run_two <= o_chan2_duty_output ? run_two + 16'h0001 : '0;
    end
  end

  chk_sleep_hiz_one: assert property (!i_sleep_request_n |=> !o_chan1_duty_oe)
    else $error("chan1 driven in sleep");
  chk_sleep_hiz_two: assert property (!i_sleep_request_n |=> !o_chan2_duty_oe)
    else $error("chan2 driven in sleep");
  chk_wake_drive: assert property (
    i_sleep_request_n |=> o_chan1_duty_oe && o_chan2_duty_oe)
    else $error("outputs not driven when awake");
  chk_high_run_one: assert property (run_one <= HIGH_MAX)
    else $error("chan1 high for a whole period");
  chk_high_run_two: assert property (run_two <= HIGH_MAX)
    else $error("chan2 high for a whole period");
  // no second rising edge in the 8 cycles after a rise, so no split pulse
  chk_one_rise_one: assert property (
    $rose(o_chan1_duty_output) |=> (!$rose(o_chan1_duty_output))[*8])
    else $error("chan1 pulse split");
  chk_one_rise_two: assert property (
    $rose(o_chan2_duty_output) |=> (!$rose(o_chan2_duty_output))[*8])
    else $error("chan2 pulse split");
  chk_slot_hold: assert property (
    $changed(o_chan1_duty_output) |=> $stable(o_chan1_duty_output))
    else $error("chan1 level shorter than a slot");
  chk_slot_hold_two: assert property (
    $changed(o_chan2_duty_output) |=> $stable(o_chan2_duty_output))
    else $error("chan2 level shorter than a slot");
  cover property (!i_sleep_request_n);
  cover property ($rose(o_chan1_duty_output));
  cover property ($fell(o_chan2_duty_output));
  cover property ($rose(o_chan1_duty_oe));
endmodule // dpd_monitor

bind dpd_top dpd_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) dpd_monitor_inst (
  .i_mclk, .i_resetn, .i_sleep_request_n, .o_chan1_duty_output,
  .o_chan1_duty_oe, .o_chan2_duty_output, .o_chan2_duty_oe
);

// ===== verif/dpd_partner.sv
module dpd_partner (
  input  wire logic i_btn,
  input  wire logic i_req1,
  input  wire logic i_req2,
  input  wire logic i_lvl1,
  input  wire logic i_lvl2,
  output logic      o_tap1,
  output logic      o_tap2
);
  timeunit 1ns;
  timeprecision 1ps;
  // logic source pulses per request; a button holds its level as long as asked
  // pins follow the bench's falling-edge drive directly, so no same-edge race
  assign o_tap1 = i_btn ? i_lvl1 : i_req1;
  assign o_tap2 = i_btn ? i_lvl2 : i_req2;
endmodule // dpd_partner

// ===== verif/dpd_top_bench.sv
module dpd_top_bench
  import dpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, f1 = 0, f2 = 0, sleep_n = 1, btn = 0;
  logic r1 = 0, r2 = 0, l1 = 0, l2 = 0, t1, t2, d1, e1, d2, e2;
  logic [7:0] h1, h2, q1[$], q2[$];
  logic [31:0] lfsr = 32'h769ebbe5;
  int error_cnt = 0, samples_checked = 0;
  event go, done;

  dpd_top #(.DEB_CYCLES(8), .DELAY_CYCLES(40), .REP_CYCLES(10), .SLOT_CYCLES(2)) dpd_top_inst (
    .i_mclk(clk), .i_resetn(rst_n), .i_chan1_float(f1), .i_chan2_float(f2),
    .i_chan1_tap_input(t1), .i_chan2_tap_input(t2), .i_sleep_request_n(sleep_n),
    .o_chan1_duty_output(d1), .o_chan1_duty_oe(e1),
    .o_chan2_duty_output(d2), .o_chan2_duty_oe(e2));
  dpd_partner dpd_partner_inst (.i_btn(btn), .i_req1(r1), .i_req2(r2),
    .i_lvl1(l1), .i_lvl2(l2), .o_tap1(t1), .o_tap2(t2));

  initial forever #10 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst(input logic b);
    rst_n = 0;
    {f1, f2, btn} = {1'b1, b, b};
    repeat (5) @(negedge clk);
    rst_n = 1;
  endtask

  task automatic tap(input int n, input logic c);
    repeat (n) begin
      @(negedge clk);
      {r2, r1} = c ? 2'b10 : 2'b01;
      @(negedge clk);
      {r2, r1} = 2'b00;
    end
  endtask

  // wait past the next period start before measuring, codes load there
  task automatic note(input logic [5:0] a, input logic [5:0] b);
    repeat (300) @(negedge clk);
    q1.push_back({1'b0, a, 1'b0});
    q2.push_back({1'b0, b, 1'b0});
    ->go;
    @done;
  endtask

  // one full period of 64 two-cycle slots: high count is twice the code
  initial forever begin
    @go;
    {h1, h2} = 16'h0000;
    repeat (128) @(negedge clk) {h1, h2} = {h1 + 8'(d1), h2 + 8'(d2)};
    check(h1, q1.pop_front());
    check(h2, q2.pop_front());
    check({6'h00, e1, e2}, 8'h03);
    $display("test %0d done", samples_checked);
    ->done;
  end

  initial begin
    rst(1'b0);
    note(CODE_HALF, CODE_HALF);
    tap(31, 0);
    note(6'h3f, CODE_HALF);
    tap(1, 0);
    tap(1, 1);
    note(6'h00, 6'h21);
    {f1, f2} = 2'b11;
    lfsr = lfsr_next(lfsr);
    tap(int'(lfsr[4:0]), 1);
    note(6'h00, 6'h21 + {1'b0, lfsr[4:0]});
    sleep_n = 0;
    repeat (50) @(negedge clk);
    check({6'h00, e1, e2}, 8'h00);
    sleep_n = 1;
    note(6'h00, 6'h21 + {1'b0, lfsr[4:0]});
    rst(1'b1);
    l2 = 1;
    repeat (3) @(negedge clk);
    {l2, l1} = 2'b01;
    repeat (700) @(negedge clk);
    note(6'h3f, CODE_HALF);
    l1 = 0;
    repeat (700) @(negedge clk);
    note(6'h00, CODE_HALF);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // dpd_top_bench
